// ==== hdl/plc_pkg.sv ====
package plc_pkg;
    // ---------------------------------------------------------------
    // clock and timing
    // ---------------------------------------------------------------
    localparam int CLK_HZ = 40_000_000;
    localparam int CLK_MHZ = CLK_HZ / 1_000_000;
    localparam int T_SETUP_NS = 2000;
    localparam int T_PULSE_NS = 50000;
    localparam int T_PULSE_EXP_NS = 1000000;
    localparam int SETUP_CYCLES = (T_SETUP_NS * CLK_MHZ + 999) / 1000;
    localparam int PULSE_CYCLES = (T_PULSE_NS * CLK_MHZ + 999) / 1000;
    localparam int PULSE_EXP_CYCLES = (T_PULSE_EXP_NS * CLK_MHZ + 999) / 1000;
    localparam int BAUD_DEFAULT = 9600;
    localparam logic [15:0] BAUD_DIV_RESET = 16'((CLK_HZ + BAUD_DEFAULT / 2) / BAUD_DEFAULT);
    localparam logic [7:0] CR_CHAR = 8'h0D;
    // ---------------------------------------------------------------
    // register offsets
    // ---------------------------------------------------------------
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_ADDR = 8'h04;
    localparam logic [7:0] OFF_WDATA = 8'h08;
    localparam logic [7:0] OFF_CYCLE = 8'h0C;
    localparam logic [7:0] OFF_STATUS = 8'h10;
    localparam logic [7:0] OFF_TXDATA = 8'h14;
    localparam logic [7:0] OFF_RXDATA = 8'h18;
    localparam logic [7:0] OFF_BAUD = 8'h1C;
    localparam int CTRL_HOLD_RESET = 0;
    localparam int CTRL_PULL_PSS = 1;
    localparam int CTRL_SERIAL_SEL = 2;
    // ---------------------------------------------------------------
    // types
    // ---------------------------------------------------------------
    typedef enum logic [2:0] {
        CK_PROGRAM = 3'h0,
        CK_SECURITY = 3'h1,
        CK_VERIFY = 3'h2,
        CK_PROG_EXP = 3'h3,
        CK_VERIFY_EXP = 3'h4,
        CK_PROG_REG = 3'h5,
        CK_VERIFY_REG = 3'h6
    } cycle_kind_t;
    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_SETUP = 4'b0010,
        ST_PULSE = 4'b0100,
        ST_HOLD = 4'b1000
    } par_state_t;
    typedef struct packed {
        logic reset_pin;
        logic pss_out;
        logic pss_oe;
        logic prog_strobe_n;
        logic vpp_enable;
        logic ea_high;
    } ctl_pins_t;
    typedef struct packed {
        logic [2:0] out;
        logic [2:0] oe;
    } mode_pins_t;
endpackage : plc_pkg

// ==== hdl/program_load_controller.sv ====
// What this block does
// - hold reset high and pull program-store strobe low to enter load configuration
// - in serial mode mode pins a and b are released, never driven
// - serial link uses only receive, transmit and ground
// - program cycle: strobe low, vpp on, mode a 1, b 0
// - verify cycle: ea high, mode a and b 0, no strobe
// - security cycle: like program with mode a and b both 1
// - expanded cycles: mode a 0, b 1, c 0; strobe only for program
// - register cycles: mode c 1 and port 2 address at 00H
// - expanded cycles get a much longer strobe and access time
// - software orders config, keys, program, verify, then lock
// - programming pulses go out on the address-latch pin
// - program-store strobe pulled open-drain and only while reset is held
// - external-access pin switched to programming voltage for program pulses
`timescale 1ns/1ps
`default_nettype none
module program_load_controller
    import plc_pkg::*;
#(
    parameter int PULSE_EXP_LEN = plc_pkg::PULSE_EXP_CYCLES
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    output plc_pkg::ctl_pins_t ctl_pins,
    output plc_pkg::mode_pins_t mode_pins,
    output logic [7:0] addr_lo,
    output logic [4:0] addr_hi,
    output logic [2:0] addr_ext,
    output logic [7:0] data_out,
    output logic data_oe,
    input wire logic [7:0] data_in,
    output logic txd,
    input wire logic rxd
);
    import plc_pkg::*;
    // ---------------------------------------------------------------
    // helpers
    // ---------------------------------------------------------------
    function automatic logic is_prog(input cycle_kind_t k);
        return k == CK_PROGRAM || k == CK_SECURITY || k == CK_PROG_EXP || k == CK_PROG_REG;
    endfunction : is_prog
    function automatic logic is_exp(input cycle_kind_t k);
        return k == CK_PROG_EXP || k == CK_VERIFY_EXP;
    endfunction : is_exp
    // returns {c, b, a}
    function automatic logic [2:0] mode_of(input cycle_kind_t k);
        case (k)
            CK_PROGRAM: return 3'h1;
            CK_SECURITY: return 3'h3;
            CK_PROG_EXP, CK_VERIFY_EXP: return 3'h2;
            CK_PROG_REG, CK_VERIFY_REG: return 3'h6;
            default: return 3'h0;
        endcase
    endfunction : mode_of
    // ---------------------------------------------------------------
    // ahb-lite slave
    // ---------------------------------------------------------------
    logic ph_wr_q, ph_rd_q;
    logic [7:0] ph_addr_q;
    logic [2:0] ctrl_q;
    logic [15:0] addr_q;
    logic [7:0] wdata_q;
    logic [15:0] baud_q;
    logic reset_held_q;
    par_state_t state_q;
    cycle_kind_t kind_q;
    logic [31:0] cnt_q;
    logic [7:0] vdata_q;
    logic [7:0] data_s1_q, data_s2_q;
    logic tx_busy_q, rx_valid_q;
    logic [7:0] rx_data_q;
    wire take = hsel & hready & htrans[1];
    wire wr_ctrl = ph_wr_q && ph_addr_q == OFF_CTRL;
    wire wr_addr = ph_wr_q && ph_addr_q == OFF_ADDR;
    wire wr_wdata = ph_wr_q && ph_addr_q == OFF_WDATA;
    wire wr_cycle = ph_wr_q && ph_addr_q == OFF_CYCLE;
    wire wr_tx = ph_wr_q && ph_addr_q == OFF_TXDATA;
    wire wr_baud = ph_wr_q && ph_addr_q == OFF_BAUD;
    wire rd_rx = ph_rd_q && ph_addr_q == OFF_RXDATA;
    wire busy = state_q != ST_IDLE;
    wire [31:0] status_w = {16'h0000, vdata_q, 5'h00, rx_valid_q, tx_busy_q, busy};
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    always_comb begin
        if (!ph_rd_q) begin
            hrdata = 32'h0000_0000;
        end else if (ph_addr_q == OFF_CTRL) begin
            hrdata = {29'h0, ctrl_q};
        end else if (ph_addr_q == OFF_ADDR) begin
            hrdata = {16'h0000, addr_q};
        end else if (ph_addr_q == OFF_WDATA) begin
            hrdata = {24'h0, wdata_q};
        end else if (ph_addr_q == OFF_STATUS) begin
            hrdata = status_w;
        end else if (ph_addr_q == OFF_RXDATA) begin
            hrdata = {24'h0, rx_data_q};
        end else if (ph_addr_q == OFF_BAUD) begin
            hrdata = {16'h0000, baud_q};
        end else begin
            hrdata = 32'h0000_0000;
        end
    end
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ph_wr_q <= 1'b0;
            ph_rd_q <= 1'b0;
            ph_addr_q <= 8'h00;
        end else begin
            ph_wr_q <= take & hwrite;
            ph_rd_q <= take & ~hwrite;
            ph_addr_q <= take ? {haddr[7:2], 2'b00} : ph_addr_q;
        end
    end
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_q <= 3'h0;
            addr_q <= 16'h0000;
            wdata_q <= 8'h00;
            baud_q <= BAUD_DIV_RESET;
            reset_held_q <= 1'b0;
        end else begin
            reset_held_q <= ctrl_q[CTRL_HOLD_RESET];
            if (wr_ctrl) ctrl_q <= hwdata[2:0];
            if (wr_addr) addr_q <= hwdata[15:0];
            if (wr_wdata) wdata_q <= hwdata[7:0];
            if (wr_baud) baud_q <= (hwdata[15:0] < 16'h0002) ? 16'h0002 : hwdata[15:0];
        end
    end
    // ---------------------------------------------------------------
    // parallel load cycles
    // ---------------------------------------------------------------
    wire hold_reset = ctrl_q[CTRL_HOLD_RESET];
    wire serial_sel = ctrl_q[CTRL_SERIAL_SEL];
    wire start_cycle = wr_cycle & ~busy & hold_reset & ~serial_sel & (hwdata[2:0] != 3'h7);
    wire [31:0] pulse_len = is_exp(kind_q) ? 32'(PULSE_EXP_LEN) : 32'(PULSE_CYCLES);
    wire [31:0] setup_len = 32'(SETUP_CYCLES);
    wire reg_kind = kind_q == CK_PROG_REG || kind_q == CK_VERIFY_REG;
    wire prog_kind = is_prog(kind_q);
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_q <= ST_IDLE;
            kind_q <= CK_PROGRAM;
            cnt_q <= 32'h0;
            vdata_q <= 8'h00;
        end else begin
            case (state_q)
                ST_IDLE: begin
                    cnt_q <= 32'h0;
                    if (start_cycle) begin
                        kind_q <= cycle_kind_t'(hwdata[2:0]);
                        state_q <= ST_SETUP;
                    end
                end
                ST_SETUP: begin
                    cnt_q <= (cnt_q == setup_len - 32'h1) ? 32'h0 : cnt_q + 32'h1;
                    if (cnt_q == setup_len - 32'h1) state_q <= ST_PULSE;
                end
                ST_PULSE: begin
                    cnt_q <= (cnt_q == pulse_len - 32'h1) ? 32'h0 : cnt_q + 32'h1;
                    if (cnt_q == pulse_len - 32'h1) state_q <= ST_HOLD;
                end
                ST_HOLD: begin
                    cnt_q <= cnt_q + 32'h1;
                    if (cnt_q == setup_len - 32'h1) begin
                        state_q <= ST_IDLE;
                        if (!prog_kind) vdata_q <= data_s2_q;
                    end
                end
                default: state_q <= ST_IDLE;
            endcase
        end
    end
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            data_s1_q <= 8'h00;
            data_s2_q <= 8'h00;
        end else begin
            data_s1_q <= data_in;
            data_s2_q <= data_s1_q;
        end
    end
    // pin drive
    assign ctl_pins.reset_pin = hold_reset;
    assign ctl_pins.pss_out = 1'b0;
    assign ctl_pins.pss_oe = hold_reset & reset_held_q
        & (ctrl_q[CTRL_PULL_PSS] | (busy & kind_q != CK_VERIFY));
    assign ctl_pins.prog_strobe_n = ~(state_q == ST_PULSE && prog_kind);
    assign ctl_pins.vpp_enable = busy & prog_kind;
    assign ctl_pins.ea_high = busy & ~prog_kind;
    assign mode_pins.out = busy ? mode_of(kind_q) : 3'h0;
    assign mode_pins.oe = (busy && !serial_sel) ? 3'h7 : 3'h0;
    assign addr_lo = busy ? addr_q[7:0] : 8'h00;
    assign addr_hi = (busy && !reg_kind) ? addr_q[12:8] : 5'h00;
    assign addr_ext = (busy && is_exp(kind_q)) ? addr_q[15:13] : 3'h0;
    assign data_out = wdata_q;
    assign data_oe = busy & prog_kind;
    // ---------------------------------------------------------------
    // uart, 8n1, three wires
    // ---------------------------------------------------------------
    logic [9:0] tx_shift_q;
    logic [3:0] tx_bit_q, rx_bit_q;
    logic [15:0] tx_cnt_q, rx_cnt_q;
    logic rxd_s1_q, rxd_s2_q, rx_active_q;
    logic [8:0] rx_shift_q;
    wire tx_tick = tx_cnt_q == baud_q - 16'h1;
    wire rx_tick = rx_cnt_q == (rx_bit_q == 4'h0 ? {1'b0, baud_q[15:1]} : baud_q - 16'h1);
    wire rx_done = rx_active_q & rx_tick & (rx_bit_q == 4'h9);
    assign txd = tx_shift_q[0];
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tx_busy_q <= 1'b0;
            tx_shift_q <= 10'h3FF;
            tx_bit_q <= 4'h0;
            tx_cnt_q <= 16'h0000;
        end else if (wr_tx && !tx_busy_q) begin
            tx_busy_q <= 1'b1;
            tx_shift_q <= {1'b1, hwdata[7:0], 1'b0};
            tx_bit_q <= 4'h0;
            tx_cnt_q <= 16'h0000;
        end else if (tx_busy_q) begin
            tx_cnt_q <= tx_tick ? 16'h0000 : tx_cnt_q + 16'h1;
            if (tx_tick) begin
                tx_shift_q <= {1'b1, tx_shift_q[9:1]};
                tx_bit_q <= tx_bit_q + 4'h1;
                tx_busy_q <= tx_bit_q != 4'h9;
            end
        end
    end
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rxd_s1_q <= 1'b1;
            rxd_s2_q <= 1'b1;
        end else begin
            rxd_s1_q <= rxd;
            rxd_s2_q <= rxd_s1_q;
        end
    end
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rx_active_q <= 1'b0;
            rx_bit_q <= 4'h0;
            rx_cnt_q <= 16'h0000;
            rx_shift_q <= 9'h000;
        end else if (!rx_active_q) begin
            rx_cnt_q <= 16'h0000;
            rx_bit_q <= 4'h0;
            rx_active_q <= ~rxd_s2_q;
        end else begin
            rx_cnt_q <= rx_tick ? 16'h0000 : rx_cnt_q + 16'h1;
            if (rx_tick) begin
                rx_bit_q <= rx_bit_q + 4'h1;
                if (rx_bit_q == 4'h0) rx_active_q <= ~rxd_s2_q;
                else rx_shift_q <= {rxd_s2_q, rx_shift_q[8:1]};
                if (rx_bit_q == 4'h9) rx_active_q <= 1'b0;
            end
        end
    end
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rx_valid_q <= 1'b0;
            rx_data_q <= 8'h00;
        end else if (rx_done && rxd_s2_q) begin
            rx_valid_q <= 1'b1;
            rx_data_q <= rx_shift_q[8:1];
        end else if (rd_rx) begin
            rx_valid_q <= 1'b0;
        end
    end
    // ---------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    sequence s_pulse_begin;
        state_q == ST_SETUP && cnt_q == setup_len - 32'h1;
    endsequence
    sequence s_pulse_low;
        !ctl_pins.prog_strobe_n [*8];
    endsequence
    logic [31:0] low_len_q;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) low_len_q <= 32'h0;
        else low_len_q <= ctl_pins.prog_strobe_n ? 32'h0 : low_len_q + 32'h1;
    end
    AST_PSS_ONLY_IN_RESET: assert property (ctl_pins.pss_oe
        |-> ctl_pins.reset_pin && $past(ctl_pins.reset_pin))
        else $error("strobe pulled without reset held");
    AST_PROG_MODE: assert property (!ctl_pins.prog_strobe_n && kind_q == CK_PROGRAM
        |-> mode_pins.out == 3'h1 && ctl_pins.vpp_enable && ctl_pins.pss_oe)
        else $error("program cycle pins wrong");
    AST_SECURITY_MODE: assert property (!ctl_pins.prog_strobe_n && kind_q == CK_SECURITY
        |-> mode_pins.out[1:0] == 2'h3 && ctl_pins.vpp_enable)
        else $error("security cycle pins wrong");
    AST_VERIFY_NO_STROBE: assert property (busy && kind_q == CK_VERIFY
        |-> ctl_pins.prog_strobe_n && ctl_pins.ea_high && mode_pins.out == 3'h0)
        else $error("verify cycle pins wrong");
    AST_EXP_MODE: assert property (busy && is_exp(kind_q)
        |-> mode_pins.out == 3'h2
        && (state_q != ST_PULSE || ctl_pins.prog_strobe_n == (kind_q == CK_VERIFY_EXP)))
        else $error("expanded cycle pins wrong");
    AST_REG_PORT2_ZERO: assert property (busy && reg_kind
        |-> addr_hi == 5'h00 && mode_pins.out[2])
        else $error("register cycle address high not zero");
    AST_SERIAL_RELEASE: assert property (serial_sel |-> mode_pins.oe == 3'h0)
        else $error("mode pins driven in serial mode");
    AST_PULSE_SHAPE: assert property (s_pulse_begin ##1 prog_kind |-> s_pulse_low)
        else $error("programming pulse too short");
    AST_EXP_LONGER: assert property ($rose(ctl_pins.prog_strobe_n)
        |-> low_len_q == (is_exp(kind_q) ? 32'(PULSE_EXP_LEN) : 32'(PULSE_CYCLES)))
        else $error("pulse length not chosen by cycle kind");
    AST_TX_START_BIT: assert property (wr_tx && !tx_busy_q |=> !txd && tx_busy_q)
        else $error("start bit missing");
endmodule : program_load_controller
`default_nettype wire

// ==== verification/load_device_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module load_device_model
    import plc_pkg::*;
#(
    // register-cycle address of the memory configuration register, plain default
    parameter logic [7:0] MEMORY_CONFIG_REGISTER_ADDR = 8'h80
) (
    input wire plc_pkg::ctl_pins_t ctl_pins,
    input wire plc_pkg::mode_pins_t mode_pins,
    input wire logic [7:0] addr_lo,
    input wire logic [4:0] addr_hi,
    input wire logic [2:0] addr_ext,
    input wire logic [7:0] data_out,
    input wire logic txd,
    output logic [7:0] data_in,
    output logic rxd,
    output logic locked,
    output logic ranged
);
    import plc_pkg::*;
    logic [7:0] mem [65536];
    logic [7:0] regs [256];
    wire logic [2:0] lvl;
    wire logic [15:0] a;
    wire logic load_mode;
    wire logic vfy;
    // ---------------------------------------------------------------
    // pins
    // ---------------------------------------------------------------
    // released mode pins sit at their pull-up level
    assign lvl = mode_pins.out | ~mode_pins.oe;
    assign a = {addr_ext, addr_hi, addr_lo};
    assign load_mode = ctl_pins.reset_pin & ctl_pins.pss_oe;
    assign vfy = ctl_pins.reset_pin & ctl_pins.ea_high & ~ctl_pins.vpp_enable & ~lvl[0];
    // port 0 floats to its pull-ups when not read back
    assign data_in = !vfy ? 8'hFF : (lvl == 3'b110) ? regs[addr_lo] : mem[a];
    // loader echoes what it receives, three wires only
    assign rxd = load_mode ? txd : 1'b1;
    initial begin
        locked = 1'b0;
        ranged = 1'b0;
    end
    // ---------------------------------------------------------------
    // program pulses
    // ---------------------------------------------------------------
    always @(posedge ctl_pins.prog_strobe_n) begin
        if (load_mode && ctl_pins.vpp_enable) begin
            ranged <= 1'b1;
            case (lvl)
                3'b001, 3'b101, 3'b010: mem[a] <= data_out;
                3'b011, 3'b111: locked <= 1'b1;
                3'b110: begin
                    regs[addr_lo] <= data_out;
                    if (addr_lo == MEMORY_CONFIG_REGISTER_ADDR && data_out[0]) begin
                        locked <= 1'b1;
                    end
                end
                default: ;
            endcase
        end
    end
endmodule : load_device_model
`default_nettype wire

// ==== verification/testbench.sv ====
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import plc_pkg::*;
    // ---------------------------------------------------------------
    // stimulus tables
    // ---------------------------------------------------------------
    localparam int BD = 16;
    typedef struct packed {
        cycle_kind_t kind;
        logic [15:0] addr;
        logic [7:0] wd;
        logic [2:0] mode;
        logic [2:0] mask;
        logic vpp;
        logic stb;
        logic [7:0] vd;
    } row_t;
    localparam row_t ROWS [7] = '{
        '{CK_PROG_REG, 16'h0080, 8'h3C, 3'b110, 3'b111, 1'b1, 1'b1, 8'h00},
        '{CK_VERIFY_REG, 16'h0080, 8'h00, 3'b110, 3'b111, 1'b0, 1'b0, 8'h3C},
        '{CK_PROGRAM, 16'h0123, 8'h5A, 3'b001, 3'b011, 1'b1, 1'b1, 8'h00},
        '{CK_VERIFY, 16'h0123, 8'h00, 3'b000, 3'b011, 1'b0, 1'b0, 8'h5A},
        '{CK_PROG_EXP, 16'h4567, 8'hC3, 3'b010, 3'b111, 1'b1, 1'b1, 8'h00},
        '{CK_VERIFY_EXP, 16'h4567, 8'h00, 3'b010, 3'b111, 1'b0, 1'b0, 8'hC3},
        '{CK_SECURITY, 16'h0000, 8'h00, 3'b011, 3'b011, 1'b1, 1'b1, 8'h00}};
    localparam logic [7:0] CMDS [14] = '{8'h0D, 8'h43, 8'h44, 8'h46, 8'h4B, 8'h4C, 8'h52,
        8'h54, 8'h55, 8'h56, 8'h57, 8'h5A, 8'h50, 8'h47};
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic hreadyout;
    logic hresp;
    logic [31:0] hrdata;
    ctl_pins_t cp;
    mode_pins_t mp;
    logic [7:0] addr_lo;
    logic [4:0] addr_hi;
    logic [2:0] addr_ext;
    logic [7:0] data_out;
    logic data_oe;
    logic [7:0] data_in;
    logic txd;
    logic rxd;
    logic locked;
    logic ranged;
    logic [31:0] s;
    int failures = 0;
    int n_checks = 0;
    always #12.5 hclk = ~hclk;
    program_load_controller #(.PULSE_EXP_LEN(200)) DUT (.hclk(hclk), .hresetn(hresetn),
        .hsel(1'b1), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
        .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
        .hrdata(hrdata), .ctl_pins(cp), .mode_pins(mp), .addr_lo(addr_lo), .addr_hi(addr_hi),
        .addr_ext(addr_ext), .data_out(data_out), .data_oe(data_oe), .data_in(data_in),
        .txd(txd), .rxd(rxd));
    load_device_model dev (.ctl_pins(cp), .mode_pins(mp), .addr_lo(addr_lo), .addr_hi(addr_hi),
        .addr_ext(addr_ext), .data_out(data_out), .txd(txd), .data_in(data_in), .rxd(rxd),
        .locked(locked), .ranged(ranged));
    // ---------------------------------------------------------------
    // tasks
    // ---------------------------------------------------------------
    task automatic finish_test;
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : finish_test
    task automatic tmo(input logic ok);
        if (!ok) begin
            failures++;
            $display("ERROR t=%0t wait ran out", $time);
            finish_test();
        end
    endtask : tmo
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            failures++;
            $display("ERROR t=%0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd,
                       output logic [31:0] d);
        int n;
        @(posedge hclk);
        haddr <= {24'h0, a};
        hwrite <= w;
        htrans <= 2'h2;
        n = 0;
        do begin
            @(posedge hclk);
            n++;
        end while (hreadyout !== 1'b1 && n < 50);
        htrans <= 2'h0;
        hwdata <= wd;
        do begin
            @(posedge hclk);
            n++;
        end while (hreadyout !== 1'b1 && n < 50);
        d = hrdata;
        tmo(n < 50);
        @(negedge hclk);
    endtask : bus
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] x;
        bus(1'b1, a, d, x);
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        bus(1'b0, a, 32'h0, d);
    endtask : rd
    task automatic idle;
        logic [31:0] st;
        int n;
        n = 0;
        do begin
            rd(OFF_STATUS, st);
            n++;
        end while (st[0] !== 1'b0 && n < 3000);
        tmo(n < 3000);
    endtask : idle
    task automatic run_row(input row_t r);
        logic [31:0] st;
        logic ex;
        ex = (r.kind == CK_PROG_EXP || r.kind == CK_VERIFY_EXP);
        wr(OFF_ADDR, {16'h0, r.addr});
        wr(OFF_WDATA, {24'h0, r.wd});
        wr(OFF_CYCLE, {29'h0, r.kind});
        repeat (4) @(negedge hclk);
        chk(mp.oe, 3'b111);
        chk(mp.out & r.mask, r.mode);
        chk({cp.reset_pin, cp.vpp_enable}, {1'b1, r.vpp});
        chk({addr_ext, addr_hi, addr_lo}, ex ? r.addr : {3'h0, r.addr[12:0]});
        if (r.vpp && r.kind != CK_SECURITY) begin
            chk({data_oe, data_out}, {1'b1, r.wd});
        end
        if (!r.vpp) begin
            chk(cp.ea_high, 1'b1);
        end
        repeat (90) @(negedge hclk);
        chk(cp.prog_strobe_n, !r.stb);
        idle();
        if (!r.vpp) begin
            rd(OFF_STATUS, st);
            chk(st[15:8], r.vd);
        end
        $display("test cycle kind %0d done", r.kind);
    endtask : run_row
    task automatic ser(input logic [7:0] b);
        logic [9:0] f;
        logic [31:0] st;
        int n;
        f = {1'b1, b, 1'b0};
        n = 0;
        wr(OFF_TXDATA, {24'h0, b});
        while (txd !== 1'b0 && n < 100) begin
            @(negedge hclk);
            n++;
        end
        tmo(n < 100);
        chk(mp.oe, 3'h0);
        repeat (BD / 2) @(negedge hclk);
        for (int i = 0; i < 10; i++) begin
            chk(txd, f[i]);
            repeat (BD) @(negedge hclk);
        end
        n = 0;
        do begin
            rd(OFF_STATUS, st);
            n++;
        end while (st[2] !== 1'b1 && n < 20);
        tmo(n < 20);
        rd(OFF_RXDATA, st);
        chk(st[7:0], b);
        rd(OFF_STATUS, st);
        chk(st[2:1], 2'b00);
        $display("test char %h done", b);
    endtask : ser
    // ---------------------------------------------------------------
    // sequence
    // ---------------------------------------------------------------
    initial begin
        repeat (100000) @(posedge hclk);
        $display("ERROR t=%0t run limit reached", $time);
        failures++;
        finish_test();
    end
    initial begin
        repeat (20) @(posedge hclk);
        hresetn <= 1'b1;
        wr(OFF_CTRL, 32'h1);
        chk({cp.reset_pin, cp.pss_oe}, 2'b10);
        wr(OFF_CTRL, 32'h3);
        chk({cp.reset_pin, cp.pss_oe}, 2'b11);
        $display("test entry done");
        foreach (ROWS[i]) run_row(ROWS[i]);
        chk({locked, ranged}, 2'b11);
        wr(OFF_CTRL, 32'h7);
        wr(OFF_CYCLE, {29'h0, CK_PROGRAM});
        rd(OFF_STATUS, s);
        chk({s[0], mp.oe}, 4'h0);
        wr(OFF_CTRL, 32'h3);
        wr(OFF_CYCLE, 32'h7);
        rd(OFF_STATUS, s);
        chk(s[0], 1'b0);
        rd(8'h40, s);
        chk(s, 32'h0);
        chk({31'h0, hresp}, 32'h0);
        $display("test refusals done");
        wr(OFF_CTRL, 32'h7);
        wr(OFF_BAUD, 32'(BD));
        rd(OFF_BAUD, s);
        chk(s[15:0], 16'(BD));
        foreach (CMDS[i]) ser(CMDS[i]);
        wr(OFF_CTRL, 32'h3);
        wr(OFF_ADDR, 32'h1);
        wr(OFF_CYCLE, {29'h0, CK_PROGRAM});
        repeat (100) @(negedge hclk);
        chk(cp.prog_strobe_n, 1'b0);
        @(posedge hclk);
        hresetn <= 1'b0;
        repeat (3) @(negedge hclk);
        chk({cp, mp, data_oe, txd}, {6'b000100, 6'h0, 1'b0, 1'b1});
        @(posedge hclk);
        hresetn <= 1'b1;
        rd(OFF_BAUD, s);
        chk(s[15:0], BAUD_DIV_RESET);
        rd(OFF_CTRL, s);
        chk(s[2:0], 3'h0);
        $display("test reset done");
        finish_test();
    end
endmodule : testbench
`default_nettype wire
